// ---- rtl/pis_regs.svh ----
// register offsets, field positions and reset values of the isolation block
// assumes: included by bare name after the package, word-aligned byte offsets
`ifndef PIS_REGS_SVH
`define PIS_REGS_SVH
`define PIS_OFF_CTRL 4'h0
`define PIS_OFF_STAT 4'h4
`define PIS_BIT_ISO 0
`define PIS_RST_CTRL 1'h0
`define PIS_RST_GATE 1'h0
`define PIS_DEP_W 4
`define PIS_MODE_W 2
`endif

// ---- rtl/pis_pkg.sv ----
// types shared by the isolation block files
// assumes: compiled before every module that imports it
package pis_pkg;
  typedef enum logic [1:0] {
    PIS_MODE_LUT,
    PIS_MODE_GATED,
    PIS_MODE_MUXED
  } pis_mode_e;
  typedef enum logic [1:0] {
    PIS_DEC_NONE,
    PIS_DEC_CTRL,
    PIS_DEC_STAT
  } pis_dec_e;
endpackage

// ---- rtl/pis_sync.sv ----
// secondary synchroniser chain for one isolated interface
// assumes: single clock; en_i is a one-cycle tick from the interface reference clock
`timescale 1ns/1ps
`default_nettype none
module pis_sync #(
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic d_i,
  output logic q_o
);
  logic [DEPTH-1:0] sh_ff;

  // each stage only feeds the next one; nothing else taps the chain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_ff <= '0;
    end else if (en_i) begin
      sh_ff <= {sh_ff[DEPTH-2:0], d_i};
    end
  end

  assign q_o = sh_ff[DEPTH-1];
endmodule
`default_nettype wire

// ---- rtl/pis_top.sv ----
// isolation block: forces partition signals to zero, reports state, syncs control
// assumes: one 40 MHz clock; reference clocks arrive as plain pins and are sampled
//
// Notes on behaviour
// - status pin is combinational, unregistered
// - status register readable over the bus
// - status stream carries live isolation state
// - each status path optional, none legal
// - per-interface status valid in its domain
// - default isolation uses plain mux logic
// - gated option glitch free, waits for low
// - gated option meant for clocks only
// - muxed option instant, ignore-low held high
// - crossing interface gets its reference clock
// - first stage on control clock with ports
// - no ports: control reference clock drives stage
// - synchroniser depth set per interface
// - isolate request is OR of sources
// - isolated signals forced to zero
// - register read: state in bit 0
`timescale 1ns/1ps
`default_nettype none
`include "pis_regs.svh"
module pis_top import pis_pkg::*; #(
  parameter int N_IF = 2,
  parameter int W = 8,
  parameter bit EN_CTRL_PIN = 1'b1,
  parameter bit EN_REG = 1'b1,
  parameter bit EN_SCTRL = 1'b1,
  parameter bit EN_ST_PIN = 1'b1,
  parameter bit EN_ST_STRM = 1'b1,
  parameter logic [N_IF-1:0] CDC_EN = 2'h3,
  parameter logic [`PIS_DEP_W*N_IF-1:0] SYNC_DEPTH = 8'h23,
  parameter logic [`PIS_MODE_W*N_IF-1:0] IF_MODE = 4'h0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // isolate request pin, also fed by a manager or a master block
  input wire logic manager_isolate_request_i,
  output wire logic iso_status_o,
  // status stream master
  output logic m_status_tvalid_o,
  output logic [31:0] m_status_tdata_o,
  // control stream slave
  input wire logic s_ctrl_tvalid_i,
  input wire logic [31:0] s_ctrl_tdata_i,
  output logic s_ctrl_tready_o,
  // reference clocks, sampled as pins
  input wire logic ctrl_ref_clk_i,
  input wire logic [N_IF-1:0] if_ref_clk_i,
  output wire logic [N_IF-1:0] if_status_o,
  // partition side and static side
  input wire logic [N_IF*W-1:0] rp_data_i,
  output wire logic [N_IF*W-1:0] s_data_o
);
  localparam bit HAS_AXI = EN_REG | EN_SCTRL | EN_ST_STRM;

  function automatic pis_dec_e pis_decode(input logic [3:0] adr);
    pis_dec_e d;
    d = PIS_DEC_NONE;
    if (EN_REG && adr == `PIS_OFF_CTRL) begin
      d = PIS_DEC_CTRL;
    end else if (EN_REG && adr == `PIS_OFF_STAT) begin
      d = PIS_DEC_STAT;
    end
    return d;
  endfunction

  // a settled rising edge: second and third samples agree high and the last seen level was low
  function automatic logic pis_rise(input logic s2, input logic s3, input logic lvl);
    return (s2 == s3) && s3 && !lvl;
  endfunction

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic reg_ctrl_ff;
  logic strm_ctrl_ff;
  logic iso_req;
  logic ack_ff;
  logic err_ff;
  logic [31:0] dat_ff;
  logic tvalid_ff;
  logic [31:0] tdata_ff;
  logic tready_ff;
  logic prim_ff;
  logic cr1_ff, cr2_ff, cr3_ff, clvl_ff;
  logic prim_en;
  logic wb_req;
  pis_dec_e wb_dec;

  // pin path is unregistered so a chain of blocks follows without delay
  assign iso_req = (EN_CTRL_PIN & manager_isolate_request_i)
                 | (EN_REG & reg_ctrl_ff)
                 | (EN_SCTRL & strm_ctrl_ff);

  // drives slave blocks directly, hence no register in the way
  assign iso_status_o = EN_ST_PIN & iso_req;

  AST_STATUS_COMB: assert property (
    (EN_ST_PIN && EN_CTRL_PIN && $rose(manager_isolate_request_i)) |-> iso_status_o)
    else $error("status pin lags the isolate request");

  AST_OR_SRC: assert property (
    (EN_CTRL_PIN && manager_isolate_request_i) |-> iso_req)
    else $error("pin request not reflected in isolate request");

  // wishbone slave
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
  assign wb_dec = pis_decode(wb_adr_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      ack_ff <= wb_req && (wb_dec != PIS_DEC_NONE);
      err_ff <= wb_req && (wb_dec == PIS_DEC_NONE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= '0;
    end else if (wb_req) begin
      dat_ff <= '0;
      if (wb_dec == PIS_DEC_CTRL) begin
        dat_ff[`PIS_BIT_ISO] <= reg_ctrl_ff;
      end else if (wb_dec == PIS_DEC_STAT) begin
        dat_ff[`PIS_BIT_ISO] <= iso_req;
      end
    end else if (!wb_cyc_i) begin
      dat_ff <= '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_ctrl_ff <= `PIS_RST_CTRL;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_dec == PIS_DEC_CTRL) begin
      reg_ctrl_ff <= wb_dat_i[`PIS_BIT_ISO];
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_err_o = err_ff;
  assign wb_dat_o = dat_ff;

  // a write lands at the taking edge; lane 0 gates it
  AST_CTRL_WRITE: assert property (
    (wb_req && wb_we_i && wb_sel_i[0] && wb_dec == PIS_DEC_CTRL) |=> (reg_ctrl_ff == $past(wb_dat_i[`PIS_BIT_ISO])))
    else $error("control write did not land");

  AST_CTRL_LANE: assert property (
    (wb_req && !(wb_we_i && wb_sel_i[0] && wb_dec == PIS_DEC_CTRL)) |=> $stable(reg_ctrl_ff))
    else $error("control register moved without a write");

  AST_REG_READ: assert property (
    (wb_req && !wb_we_i && wb_dec == PIS_DEC_STAT) |=>
      (wb_ack_o && wb_dat_o == {31'h0, $past(iso_req)}))
    else $error("status read returned wrong data");

  AST_ACK_PULSE: assert property (
    (wb_cyc_i && wb_stb_i && !ack_ff && !err_ff) |=> (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o))
    else $error("bus answer is not a single one-cycle pulse");

  // control stream: always ready, bit 0 holds the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tready_ff <= 1'b0;
      strm_ctrl_ff <= `PIS_RST_CTRL;
    end else begin
      tready_ff <= EN_SCTRL;
      if (s_ctrl_tvalid_i && tready_ff) begin
        strm_ctrl_ff <= s_ctrl_tdata_i[`PIS_BIT_ISO];
      end
    end
  end

  assign s_ctrl_tready_o = tready_ff;

  AST_STRM_CTRL: assert property (
    (EN_SCTRL && s_ctrl_tvalid_i && s_ctrl_tready_o) |=> (strm_ctrl_ff == $past(s_ctrl_tdata_i[`PIS_BIT_ISO])))
    else $error("control stream word not taken");

  // status stream: a continuous sample of the live state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tvalid_ff <= 1'b0;
      tdata_ff <= '0;
    end else begin
      tvalid_ff <= EN_ST_STRM;
      tdata_ff <= '0;
      tdata_ff[`PIS_BIT_ISO] <= EN_ST_STRM & iso_req;
    end
  end

  assign m_status_tvalid_o = tvalid_ff;
  assign m_status_tdata_o = tdata_ff;

  AST_STREAM_LIVE: assert property (
    EN_ST_STRM |-> ##1 (m_status_tvalid_o && m_status_tdata_o[`PIS_BIT_ISO] == $past(iso_req)))
    else $error("status stream lags or misreports the state");

  // control reference clock, three samples; first flop feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cr1_ff <= 1'b0;
      cr2_ff <= 1'b0;
      cr3_ff <= 1'b0;
      clvl_ff <= 1'b0;
    end else begin
      cr1_ff <= ctrl_ref_clk_i;
      cr2_ff <= cr1_ff;
      cr3_ff <= cr2_ff;
      if (cr2_ff == cr3_ff) begin
        clvl_ff <= cr3_ff;
      end
    end
  end

  // with a bus present the control clock steps the first stage every cycle
  assign prim_en = HAS_AXI ? 1'b1 : pis_rise(cr2_ff, cr3_ff, clvl_ff);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prim_ff <= 1'b0;
    end else if (prim_en) begin
      prim_ff <= iso_req;
    end
  end

  AST_PRIM_STAGE: assert property (HAS_AXI |-> ##1 (prim_ff == $past(iso_req)))
    else $error("first stage missed the control clock");

  // without a bus the first stage only moves on a settled control reference edge
  AST_PRIM_REF: assert property ((!HAS_AXI && !prim_en) |=> $stable(prim_ff))
    else $error("first stage moved between reference edges");

  for (genvar i = 0; i < N_IF; i++) begin : g_if
    localparam int DEP = int'(SYNC_DEPTH[`PIS_DEP_W*i +: `PIS_DEP_W]);
    localparam pis_mode_e MODE = pis_mode_e'(IF_MODE[`PIS_MODE_W*i +: `PIS_MODE_W]);
    logic ctl;
    logic [W-1:0] din;
    assign din = rp_data_i[W*i +: W];

    if (CDC_EN[i]) begin : g_cdc
      logic r1_ff, r2_ff, r3_ff, lvl_ff;
      logic tick;
      logic sq;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          r1_ff <= 1'b0;
          r2_ff <= 1'b0;
          r3_ff <= 1'b0;
          lvl_ff <= 1'b0;
        end else begin
          r1_ff <= if_ref_clk_i[i];
          r2_ff <= r1_ff;
          r3_ff <= r2_ff;
          if (r2_ff == r3_ff) begin
            lvl_ff <= r3_ff;
          end
        end
      end
      assign tick = pis_rise(r2_ff, r3_ff, lvl_ff);
      pis_sync #(.DEPTH(DEP)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(tick),
        .d_i(prim_ff),
        .q_o(sq)
      );
      // status and mux share one source so software never sees a mismatch
      assign ctl = sq;
      assign if_status_o[i] = sq;

      // the interface status may only move on a tick of its own reference clock
      AST_IF_STATUS: assert property (!tick |=> $stable(if_status_o[i]))
        else $error("interface status moved outside its clock domain");
    end else begin : g_nocdc
      assign ctl = iso_req;
      assign if_status_o[i] = 1'b0;
    end

    if (MODE == PIS_MODE_GATED) begin : g_gated
      // intended for clocks: enable moves only while the input is low
      logic [W-1:0] gate_ff;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          gate_ff <= {W{`PIS_RST_GATE}};
        end else begin
          for (int b = 0; b < W; b++) begin
            if (!din[b]) begin
              gate_ff[b] <= ctl;
            end
          end
        end
      end
      assign s_data_o[W*i +: W] = din & ~gate_ff;

      AST_GATED_WAIT: assert property (
        (gate_ff & $past(din)) == ($past(gate_ff) & $past(din)))
        else $error("gated isolation moved on a high input");
      AST_GATED_FORCE: assert property (
        $past(ctl) |-> ((~gate_ff & ~$past(din)) == '0))
        else $error("gated isolation missed a low input");
    end else if (MODE == PIS_MODE_MUXED) begin : g_muxed
      // ignore-low input held at 1: switches at once, no glitch guarantee
      localparam logic IGNORE_LOW_INPUT = 1'b1;
      assign s_data_o[W*i +: W] = (ctl && IGNORE_LOW_INPUT) ? '0 : din;

      AST_MUXED_NOW: assert property (ctl |-> s_data_o[W*i +: W] == '0)
        else $error("muxed isolation not instant");
    end else begin : g_lut
      assign s_data_o[W*i +: W] = ctl ? '0 : din;

      AST_LUT_FORCE: assert property (
        ctl |-> s_data_o[W*i +: W] == '0)
        else $error("isolated output not forced to zero");
      AST_LUT_PASS: assert property (!ctl |-> s_data_o[W*i +: W] == din)
        else $error("pass-through altered data");
    end
  end
endmodule
`default_nettype wire

// ---- bench/pis_far_model.sv ----
// far side of the isolation block: partition data source and reference clocks
// assumes: clk_i is the 40 MHz block clock; reference clocks run free
`timescale 1ns/1ps
`default_nettype none
module pis_far_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] data_i,
  output logic [15:0] rp_data_o,
  output logic ctrl_ref_clk_o,
  output logic [1:0] if_ref_clk_o
);
  logic [3:0] cnt_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
  // each level lasts at least 4 cycles so the pin sampler can settle
  assign if_ref_clk_o = {cnt_ff[3], cnt_ff[2]};
  assign ctrl_ref_clk_o = cnt_ff[3];
  always_ff @(posedge clk_i) begin
    rp_data_o <= data_i;
  end
endmodule
`default_nettype wire

// ---- bench/partition_isolation_status_sync_tb.sv ----
// self-checking bench of the isolation block with bus, pin and stream stimulus
// assumes: if0 crosses with depth 3 in lut mode, if1 has no crossing in muxed mode
`timescale 1ns/1ps
`default_nettype none
module partition_isolation_status_sync_tb;
  logic clk_i, rst_i, cyc, stb, we, iso_req, c_tvalid, ack, err, iso_st, st_tvalid, c_tready, ctrl_ref;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, c_tdata, st_tdata, lfsr_ff;
  logic [1:0] if_ref, if_st;
  logic [15:0] rp_src, rp_data, s_data;
  logic [15:0] s_data2;
  logic [1:0] dly, if_st2;
  logic st2_pin, st2_tv;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int fail_count, tests_run, cyc_cnt, n;

  pis_top #(.CDC_EN(2'h1), .IF_MODE(4'h8)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .manager_isolate_request_i(iso_req), .iso_status_o(iso_st),
    .m_status_tvalid_o(st_tvalid), .m_status_tdata_o(st_tdata), .s_ctrl_tvalid_i(c_tvalid),
    .s_ctrl_tdata_i(c_tdata), .s_ctrl_tready_o(c_tready), .ctrl_ref_clk_i(ctrl_ref),
    .if_ref_clk_i(if_ref), .if_status_o(if_st), .rp_data_i(rp_data), .s_data_o(s_data));
  pis_far_model i_far (.clk_i(clk_i), .rst_i(rst_i), .data_i(rp_src), .rp_data_o(rp_data),
    .ctrl_ref_clk_o(ctrl_ref), .if_ref_clk_o(if_ref));
  // slave block with no bus and no status path: first stage runs on the control reference
  pis_top #(.EN_REG(1'b0), .EN_SCTRL(1'b0), .EN_ST_PIN(1'b0), .EN_ST_STRM(1'b0), .CDC_EN(2'h1),
    .IF_MODE(4'h1)) i_dut_slave (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(1'b0), .wb_stb_i(1'b0),
    .wb_we_i(1'b0), .wb_adr_i(4'h0), .wb_sel_i(4'h0), .wb_dat_i(32'h0), .wb_dat_o(), .wb_ack_o(),
    .wb_err_o(), .manager_isolate_request_i(dly[1]), .iso_status_o(st2_pin), .m_status_tvalid_o(st2_tv),
    .m_status_tdata_o(), .s_ctrl_tvalid_i(1'b0), .s_ctrl_tdata_i(32'h0), .s_ctrl_tready_o(),
    .ctrl_ref_clk_i(ctrl_ref), .if_ref_clk_i(if_ref), .if_status_o(if_st2), .rp_data_i(rp_data),
    .s_data_o(s_data2));

  // two-cycle delay line from the master's status pin to the slave's request pin
  always @(posedge clk_i) begin
    dly <= {dly[0], iso_st};
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // e is {compare data, expect error, data}; entered at a rising edge
  task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d,
                         input logic [33:0] x);
    exp_q.push_back(x);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1 && err !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  // scoreboard: the oldest note is compared whenever the slave answers
  always @(posedge clk_i) begin
    if (ack === 1'b1 || err === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected answer", 32'h0, 32'h1);
      end else begin
        e = exp_q.pop_front();
        chk("bus error flag", {31'h0, e[32]}, {31'h0, err});
        if (e[33]) begin
          chk("read data", e[31:0], rdat);
        end
      end
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    lfsr_ff <= lfsr_next(lfsr_ff);
    rp_src <= lfsr_ff[15:0];
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      fail_count++;
      $display("ERROR timeout expected 0 seen %0d", cyc_cnt);
      give_verdict();
    end
  end

  task automatic strm(input logic v);
    @(posedge clk_i);
    c_tvalid <= 1'b1;
    c_tdata <= {31'h0, v};
    @(posedge clk_i);
    c_tvalid <= 1'b0;
    @(negedge clk_i);
    chk("state after stream", {31'h0, v}, {31'h0, iso_st});
  endtask

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, iso_req, c_tvalid} = 5'h0;
    {adr, sel} = 8'h0;
    {wdat, c_tdata} = 64'h0;
    rp_src = 16'h0;
    dly = 2'h0;
    lfsr_ff = 32'h520b;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    @(negedge clk_i);
    chk("status valid", 32'h1, {31'h0, st_tvalid});
    @(posedge clk_i);
    wb_xfer(1'b0, 4'h4, 4'hf, 32'h0, {2'b10, 32'h0});
    wb_xfer(1'b0, 4'h8, 4'hf, 32'h0, {2'b01, 32'h0});
    iso_req <= 1'b1;
    @(negedge clk_i);
    chk("pin state", 32'h1, {31'h0, iso_st});
    chk("muxed forced", 32'h0, {24'h0, s_data[15:8]});
    chk("if0 not yet", 32'h0, {31'h0, if_st[0]});
    chk("if0 pass", {24'h0, rp_data[7:0]}, {24'h0, s_data[7:0]});
    chk("slave waits", {24'h0, rp_data[15:8]}, {24'h0, s_data2[15:8]});
    @(negedge clk_i);
    chk("stream state", 32'h1, st_tdata);
    chk("slave still waits", {24'h0, rp_data[15:8]}, {24'h0, s_data2[15:8]});
    @(negedge clk_i);
    chk("slave forced", 32'h0, {24'h0, s_data2[15:8]});
    chk("slave no status", 32'h0, {30'h0, st2_tv, st2_pin});
    n = 0;
    while (if_st[0] !== 1'b1 && n < 80) begin
      @(negedge clk_i);
      n++;
    end
    chk("if0 state", 32'h1, {31'h0, if_st[0]});
    chk("if0 forced", 32'h0, {24'h0, s_data[7:0]});
    chk("if1 no crossing", 32'h0, {31'h0, if_st[1]});
    n = 0;
    while (if_st2[0] !== 1'b1 && n < 160) begin
      @(negedge clk_i);
      n++;
    end
    chk("slave if0 state", 32'h1, {31'h0, if_st2[0]});
    repeat (24) @(negedge clk_i);
    chk("slave gated forced", 32'h0, {24'h0, s_data2[7:0]});
    @(posedge clk_i);
    iso_req <= 1'b0;
    @(negedge clk_i);
    chk("pin released", 32'h0, {31'h0, iso_st});
    chk("muxed pass", {24'h0, rp_data[15:8]}, {24'h0, s_data[15:8]});
    chk("slave held", 32'h0, {24'h0, s_data2[15:8]});
    repeat (2) @(negedge clk_i);
    chk("slave recoupled", {24'h0, rp_data[15:8]}, {24'h0, s_data2[15:8]});
    @(posedge clk_i);
    wb_xfer(1'b1, 4'h0, 4'hf, 32'h1, {2'b00, 32'h0});
    wb_xfer(1'b0, 4'h4, 4'hf, 32'h0, {2'b10, 32'h1});
    chk("reg state", 32'h1, {31'h0, iso_st});
    wb_xfer(1'b1, 4'h0, 4'he, 32'h0, {2'b00, 32'h0});
    wb_xfer(1'b0, 4'h0, 4'hf, 32'h0, {2'b10, 32'h1});
    wb_xfer(1'b1, 4'h0, 4'hf, 32'h0, {2'b00, 32'h0});
    wb_xfer(1'b0, 4'h4, 4'hf, 32'h0, {2'b10, 32'h0});
    strm(1'b1);
    strm(1'b0);
    repeat (100) @(negedge clk_i);
    chk("slave if0 released", 32'h0, {31'h0, if_st2[0]});
    chk("slave gated pass", {24'h0, rp_data[7:0]}, {24'h0, s_data2[7:0]});
    repeat (2) @(posedge clk_i);
    chk("notes left", 32'h0, exp_q.size());
    give_verdict();
  end
endmodule
`default_nettype wire
